// [rtl/wprcf_framer.sv]
// Receiver comm framer: protocol phases, packet and byte framing, modulation.
// Assumes UVLO and mode inputs come from other clock domains or pins.
`timescale 1ns/1ps
`include "wprcf_defines.svh"
module wprcf_framer (
  input wire logic CLK_I, // 10 MHz system clock.
  input wire logic RST_I, // Asynchronous reset, active high.
  input wire logic UVLO_OK_I, // Rectified voltage above UVLO threshold.
  input wire logic DEMODULATED_INPUT_I, // Demodulated input above threshold.
  input wire logic END_POWER_REQ_I, // Request end of power transfer.
  input wire logic PING_INVALID_I, // Invalid response to send in ping.
  input wire logic NEG_DONE_I, // Negotiation finished.
  input wire logic RENEG_REQ_I, // Enter renegotiation.
  input wire logic RENEG_ABORT_I, // Abort renegotiation early.
  input wire logic RENEG_DONE_I, // Renegotiation accepted.
  input wire logic GRANT_I, // Transmitter granted last request.
  input wire logic DENY_I, // Transmitter denied last request.
  input wire logic [7:0] CTRL_ERR_I, // Control error value.
  input wire logic [7:0] RX_POWER_I, // Received power value.
  input wire logic [7:0] SIG_STRENGTH_I, // Signal strength value.
  input wire logic [7:0] NEG_REQ_I, // Negotiation request value.
  input wire logic [7:0] CONTRACT_I, // New contract value on renegotiation.
  output logic [2:0] PHASE_O, // Current protocol phase.
  output logic [7:0] CONTRACT_O, // Active power transfer contract.
  output logic MOD_CAP_PIN_A_O, // Ground modulation cap on terminal A.
  output logic MOD_CAP_PIN_B_O, // Ground modulation cap on terminal B.
  output logic PKT_DONE_O // Pulse after each packet sent.
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers; all single-bit control inputs are asynchronous pins.
  localparam int NS = 9;
  logic [NS-1:0] raw, s1_reg, s2_reg;
  assign raw = {UVLO_OK_I, DEMODULATED_INPUT_I, END_POWER_REQ_I, PING_INVALID_I,
                NEG_DONE_I, RENEG_REQ_I, RENEG_ABORT_I, RENEG_DONE_I, GRANT_I};
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  logic uvlo_ok, end_req, ping_bad, neg_done, reneg_req, reneg_abort, reneg_done;
  logic grant_in;
  logic deny_s1_reg, deny_s2_reg;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      deny_s1_reg <= 1'b0;
      deny_s2_reg <= 1'b0;
    end else begin
      deny_s1_reg <= DENY_I;
      deny_s2_reg <= deny_s1_reg;
    end
  end
  assign uvlo_ok = s2_reg[8] | s2_reg[7];
  assign end_req = s2_reg[6];
  assign ping_bad = s2_reg[5];
  assign neg_done = s2_reg[4];
  assign reneg_req = s2_reg[3];
  assign reneg_abort = s2_reg[2];
  assign reneg_done = s2_reg[1];
  assign grant_in = s2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // Packet selection per phase.
  wprcf_pkg::wprcf_phase_t phase_reg;
  logic tx_busy, pkt_done;
  logic [7:0] hdr_sel, msg_sel;
  logic idcfg_sent_id_reg;
  logic neg_wait_reg;
  logic [1:0] xfer_slot_reg;
  always_comb begin
    hdr_sel = `WPRCF_HDR_CTRL_ERROR;
    msg_sel = CTRL_ERR_I;
    unique case (phase_reg)
      wprcf_pkg::PH_SELECT: begin
        hdr_sel = `WPRCF_HDR_SIG_STRENGTH;
        msg_sel = SIG_STRENGTH_I;
      end
      wprcf_pkg::PH_PING: begin
        hdr_sel = (end_req || ping_bad) ? `WPRCF_HDR_END_POWER
                                        : `WPRCF_HDR_SIG_STRENGTH;
        msg_sel = SIG_STRENGTH_I;
      end
      wprcf_pkg::PH_IDCFG: begin
        hdr_sel = idcfg_sent_id_reg ? `WPRCF_HDR_CONFIG : `WPRCF_HDR_IDENT;
        msg_sel = 8'h00;
      end
      wprcf_pkg::PH_NEGOT, wprcf_pkg::PH_RENEG: begin
        hdr_sel = `WPRCF_HDR_NEG_REQ;
        msg_sel = NEG_REQ_I;
      end
      wprcf_pkg::PH_CALIB: begin
        hdr_sel = `WPRCF_HDR_RX_POWER;
        msg_sel = RX_POWER_I;
      end
      wprcf_pkg::PH_XFER: begin
        hdr_sel = xfer_slot_reg[0] ? `WPRCF_HDR_RX_POWER : `WPRCF_HDR_CTRL_ERROR;
        msg_sel = xfer_slot_reg[0] ? RX_POWER_I : CTRL_ERR_I;
        if (end_req) begin
          hdr_sel = `WPRCF_HDR_END_POWER;
          msg_sel = 8'h00;
        end
      end
      wprcf_pkg::PH_END: begin
        hdr_sel = `WPRCF_HDR_END_POWER;
        msg_sel = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol phase sequencing.
  logic [7:0] sent_hdr_reg;
  logic want_tx;
  // Holding off in transfer while renegotiation is asked for keeps a control
  // packet from starting in the very cycle of the phase change.
  assign want_tx = (phase_reg != wprcf_pkg::PH_SELECT) && !neg_wait_reg &&
                   !(phase_reg == wprcf_pkg::PH_XFER && reneg_req);
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase_reg <= wprcf_pkg::PH_SELECT;
      idcfg_sent_id_reg <= 1'b0;
      xfer_slot_reg <= '0;
      neg_wait_reg <= 1'b0;
      CONTRACT_O <= 8'h00;
    end else if (!uvlo_ok) begin
      phase_reg <= wprcf_pkg::PH_SELECT;
      idcfg_sent_id_reg <= 1'b0;
      neg_wait_reg <= 1'b0;
    end else begin
      unique case (phase_reg)
        wprcf_pkg::PH_SELECT: phase_reg <= wprcf_pkg::PH_PING;
        wprcf_pkg::PH_PING: begin
          if (pkt_done && sent_hdr_reg == `WPRCF_HDR_SIG_STRENGTH) begin
            phase_reg <= wprcf_pkg::PH_IDCFG;
          end
          // An end packet or invalid response keeps the phase here.
        end
        wprcf_pkg::PH_IDCFG: begin
          if (pkt_done && sent_hdr_reg == `WPRCF_HDR_IDENT) begin
            idcfg_sent_id_reg <= 1'b1;
          end else if (pkt_done && sent_hdr_reg == `WPRCF_HDR_CONFIG) begin
            phase_reg <= wprcf_pkg::PH_NEGOT;
          end
        end
        wprcf_pkg::PH_NEGOT, wprcf_pkg::PH_RENEG: begin
          // Each request is held until the transmitter answers it.
          if (pkt_done) begin
            neg_wait_reg <= 1'b1;
          end else if (grant_in || deny_s2_reg) begin
            neg_wait_reg <= 1'b0;
          end
          if (phase_reg == wprcf_pkg::PH_NEGOT && neg_done) begin
            phase_reg <= wprcf_pkg::PH_CALIB;
            neg_wait_reg <= 1'b0;
          end
          if (phase_reg == wprcf_pkg::PH_RENEG) begin
            if (reneg_abort) begin
              phase_reg <= wprcf_pkg::PH_XFER;
              neg_wait_reg <= 1'b0;
            end else if (reneg_done) begin
              CONTRACT_O <= CONTRACT_I;
              phase_reg <= wprcf_pkg::PH_XFER;
              neg_wait_reg <= 1'b0;
            end
          end
        end
        wprcf_pkg::PH_CALIB: begin
          if (pkt_done) begin
            phase_reg <= wprcf_pkg::PH_XFER;
          end
        end
        wprcf_pkg::PH_XFER: begin
          if (pkt_done) begin
            // A request finished after an abort must not skew the alternation.
            if (sent_hdr_reg != `WPRCF_HDR_NEG_REQ) begin
              xfer_slot_reg <= xfer_slot_reg + 2'h1;
            end
            if (sent_hdr_reg == `WPRCF_HDR_END_POWER) begin
              phase_reg <= wprcf_pkg::PH_END;
            end
          end else if (reneg_req && !tx_busy) begin
            phase_reg <= wprcf_pkg::PH_RENEG;
          end
        end
        wprcf_pkg::PH_END: phase_reg <= wprcf_pkg::PH_END;
      endcase
    end
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PHASE_O <= 3'h0;
    end else begin
      PHASE_O <= 3'(phase_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Packet serialiser: preamble ones, then 11-bit frames per byte.
  wprcf_pkg::wprcf_tx_t tx_reg;
  logic [7:0] msg_reg, chk_reg;
  logic [1:0] byte_idx_reg;
  logic [3:0] fbit_reg;
  logic [4:0] pre_cnt_reg;
  logic [10:0] frame_reg;
  logic enc_go, enc_bit, enc_busy, enc_done, enc_level;
  function automatic logic [10:0] make_frame(input logic [7:0] b);
    // LSB first after a zero start bit; odd parity; stop bit one.
    make_frame = {1'b1, ~(^b), b, 1'b0};
  endfunction
  assign tx_busy = tx_reg != wprcf_pkg::ST_IDLE;
  assign pkt_done = enc_done && tx_reg == wprcf_pkg::ST_FRAME &&
                    fbit_reg == `WPRCF_FRAME_BITS - 4'h1 && byte_idx_reg == 2'h2;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_reg <= wprcf_pkg::ST_IDLE;
      msg_reg <= 8'h00;
      chk_reg <= 8'h00;
      sent_hdr_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      fbit_reg <= 4'h0;
      pre_cnt_reg <= 5'h00;
      frame_reg <= '0;
    end else begin
      unique case (tx_reg)
        wprcf_pkg::ST_IDLE: begin
          if (want_tx && uvlo_ok && !pkt_done) begin
            sent_hdr_reg <= hdr_sel;
            msg_reg <= msg_sel;
            chk_reg <= hdr_sel ^ msg_sel;
            pre_cnt_reg <= 5'h00;
            tx_reg <= wprcf_pkg::ST_PRE;
          end
        end
        wprcf_pkg::ST_PRE: begin
          if (enc_done) begin
            if (pre_cnt_reg == `WPRCF_PREAMBLE_BITS - 5'h01) begin
              tx_reg <= wprcf_pkg::ST_FRAME;
              byte_idx_reg <= 2'h0;
              fbit_reg <= 4'h0;
              frame_reg <= make_frame(sent_hdr_reg);
            end else begin
              pre_cnt_reg <= pre_cnt_reg + 5'h01;
            end
          end
        end
        wprcf_pkg::ST_FRAME: begin
          if (enc_done) begin
            if (fbit_reg == `WPRCF_FRAME_BITS - 4'h1) begin
              fbit_reg <= 4'h0;
              if (byte_idx_reg == 2'h2) begin
                tx_reg <= wprcf_pkg::ST_IDLE;
              end else begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
                frame_reg <= make_frame(byte_idx_reg == 2'h0 ? msg_reg : chk_reg);
              end
            end else begin
              fbit_reg <= fbit_reg + 4'h1;
              frame_reg <= {1'b0, frame_reg[10:1]};
            end
          end
        end
      endcase
    end
  end
  assign enc_bit = (tx_reg == wprcf_pkg::ST_PRE) ? 1'b1 : frame_reg[0];
  assign enc_go = (tx_reg != wprcf_pkg::ST_IDLE) && !enc_busy && !enc_done;

  wprcf_bitenc u_enc (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .go_i(enc_go),
    .bit_i(enc_bit),
    .busy_o(enc_busy),
    .done_o(enc_done),
    .level_o(enc_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // Modulation switches follow the encoded level only while sending.
  // The level is taken relative to where the encoder stood at packet start, so
  // every packet opens with a real transition and no stray pulse.
  logic base_reg;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MOD_CAP_PIN_A_O <= 1'b0;
      MOD_CAP_PIN_B_O <= 1'b0;
      PKT_DONE_O <= 1'b0;
      base_reg <= 1'b0;
    end else begin
      if (!tx_busy) begin
        base_reg <= enc_level;
      end
      MOD_CAP_PIN_A_O <= tx_busy && (enc_level ^ base_reg);
      MOD_CAP_PIN_B_O <= tx_busy && (enc_level ^ base_reg);
      PKT_DONE_O <= pkt_done;
    end
  end
endmodule

// [include/wprcf_defines.svh]
// Timing, framing and packet constants for the receiver comm framer.
// Assumes a 10 MHz system clock driving the whole block.
`ifndef WPRCF_DEFINES_SVH
`define WPRCF_DEFINES_SVH

`define WPRCF_CLK_HZ 10000000
`define WPRCF_BIT_HZ 2000
// Half a bit cell in clock cycles: 10 MHz / (2 * 2 kHz) = 2500.
`define WPRCF_HALF_CYC (`WPRCF_CLK_HZ / (2 * `WPRCF_BIT_HZ))
`define WPRCF_HALF_W 12
`define WPRCF_FRAME_BITS 4'hb
`define WPRCF_PREAMBLE_BITS 5'h0b
`define WPRCF_MSG_MAX 8
`define WPRCF_HDR_SIG_STRENGTH 8'h01
`define WPRCF_HDR_END_POWER 8'h02
`define WPRCF_HDR_CTRL_ERROR 8'h03
`define WPRCF_HDR_RX_POWER 8'h04
`define WPRCF_HDR_IDENT 8'h71
`define WPRCF_HDR_CONFIG 8'h51
`define WPRCF_HDR_NEG_REQ 8'h20

`endif

// [include/wprcf_pkg.sv]
// Types shared by the receiver comm framer files.
// Assumes wprcf_defines.svh supplies the numeric constants.
package wprcf_pkg;
  typedef enum {
    PH_SELECT, PH_PING, PH_IDCFG, PH_NEGOT, PH_CALIB, PH_XFER, PH_RENEG, PH_END
  } wprcf_phase_t;
  typedef enum {ST_IDLE, ST_PRE, ST_FRAME} wprcf_tx_t;
endpackage

// [rtl/wprcf_bitenc.sv]
// Differential bi-phase bit encoder producing one bit cell per request.
// Assumes the caller holds bit_i steady while busy_o is high.
`timescale 1ns/1ps
`include "wprcf_defines.svh"
module wprcf_bitenc (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic go_i, // Start one bit cell.
  input wire logic bit_i, // Bit value to encode.
  output logic busy_o, // Cell in progress.
  output logic done_o, // Pulse at end of cell.
  output logic level_o // Encoded line level.
);
  logic [`WPRCF_HALF_W-1:0] cnt_reg;
  logic half_reg;
  logic bit_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      half_reg <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      bit_reg <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (go_i && !busy_o) begin
        busy_o <= 1'b1;
        bit_reg <= bit_i;
        half_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (busy_o) begin
        if (cnt_reg == `WPRCF_HALF_W'(`WPRCF_HALF_CYC - 1)) begin
          cnt_reg <= '0;
          half_reg <= ~half_reg;
          if (half_reg) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
  // Every cell opens with a toggle; a one also toggles at mid-cell.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (go_i && !busy_o) begin
      level_o <= ~level_o;
    end else if (busy_o && !half_reg && bit_reg &&
                 cnt_reg == `WPRCF_HALF_W'(`WPRCF_HALF_CYC - 1)) begin
      level_o <= ~level_o;
    end
  end
endmodule

// [verif/wprcf_tx_model.sv]
// Transmitter-side model: demodulates the load switch and answers requests.
// Assumes the framer's 10 MHz clock and its switch pin as the coil signal.
`timescale 1ns/1ps
`include "wprcf_defines.svh"
module wprcf_tx_model (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Reset, active high.
  input wire logic line_i, // Load switch seen on the coil.
  input wire logic deny_sel_i, // Deny instead of grant.
  output logic grant_o, // Request granted.
  output logic deny_o, // Request denied.
  output logic frame_valid_o, // One frame decoded.
  output logic [9:0] frame_o // Stop, parity, data.
);
  logic prev_reg, hunt_reg, pend_reg, half, full, edge_seen;
  logic [3:0] idx_reg;
  logic [9:0] sh_reg;
  logic [12:0] ans_reg;
  logic [15:0] gap_reg;
  logic [1:0] nb_reg;
  logic [7:0] hdr_reg;
  assign edge_seen = line_i != prev_reg;
  assign half = gap_reg >= `WPRCF_HALF_CYC / 2 && gap_reg < 3 * `WPRCF_HALF_CYC / 2;
  assign full = gap_reg >= 3 * `WPRCF_HALF_CYC / 2 && gap_reg <= 3 * `WPRCF_HALF_CYC;
  // Hunting skips the preamble and the idle glitch; a full cell marks the start bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {prev_reg, pend_reg, idx_reg, sh_reg, gap_reg, frame_valid_o, frame_o} <= '0;
      hunt_reg <= 1'b1;
    end else begin
      frame_valid_o <= 1'b0;
      prev_reg <= line_i;
      gap_reg <= edge_seen ? 16'h0001 : gap_reg + 16'(gap_reg != 16'hffff);
      if (edge_seen && hunt_reg && full) begin
        {hunt_reg, idx_reg, pend_reg} <= '0;
      end else if (edge_seen && !hunt_reg && (half || full)) begin
        if (half && idx_reg != 4'h9 && !pend_reg) begin
          pend_reg <= 1'b1;
        end else begin
          pend_reg <= 1'b0;
          sh_reg <= {half, sh_reg[9:1]};
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == 4'h9) begin
            hunt_reg <= 1'b1;
            frame_valid_o <= 1'b1;
            frame_o <= {half, sh_reg[9:1]};
          end
        end
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {nb_reg, hdr_reg, ans_reg} <= '0;
    end else if (frame_valid_o) begin
      nb_reg <= nb_reg == 2'h2 ? 2'h0 : nb_reg + 2'h1;
      if (nb_reg == 2'h0) hdr_reg <= frame_o[7:0];
      // The checksum decodes half a cell before the packet ends; answer after that.
      if (nb_reg == 2'h2 && hdr_reg == `WPRCF_HDR_NEG_REQ) ans_reg <= 13'h0fa0;
    end else if (ans_reg != 13'h0000) begin
      ans_reg <= ans_reg - 13'h0001;
    end
  end
  assign grant_o = ans_reg != 13'h0000 && ans_reg < 13'h0005 && !deny_sel_i;
  assign deny_o = ans_reg != 13'h0000 && ans_reg < 13'h0005 && deny_sel_i;
endmodule

// [verif/wprcf_framer_asserts.sv]
// Port-level checks of the comm framer, bound into wprcf_framer.
// Assumes one clock domain with the active-high asynchronous reset.
`timescale 1ns/1ps
module wprcf_framer_asserts (
  input wire logic CLK_I, // Clock.
  input wire logic RST_I, // Reset.
  input wire logic UVLO_OK_I, // Voltage good.
  input wire logic DEMODULATED_INPUT_I, // Alternate voltage good.
  input wire logic [7:0] CONTRACT_I, // New contract.
  input wire logic [2:0] PHASE_O, // Phase.
  input wire logic [7:0] CONTRACT_O, // Contract.
  input wire logic MOD_CAP_PIN_A_O, // Switch A.
  input wire logic MOD_CAP_PIN_B_O, // Switch B.
  input wire logic PKT_DONE_O // Packet sent.
);
  logic [15:0] run_reg;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Saturating age of the switch level, so long idle stretches stay legal.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_reg <= 16'h0000;
    end else begin
      run_reg <= $changed(MOD_CAP_PIN_A_O) ? 16'h0001 : run_reg + 16'(run_reg != 16'hffff);
    end
  end
  a_pins_same: assert property (MOD_CAP_PIN_A_O == MOD_CAP_PIN_B_O)
    else $error("switch pins differ");
  a_uvlo_select: assert property ((!UVLO_OK_I && !DEMODULATED_INPUT_I) [*5] |-> PHASE_O == 3'h0)
    else $error("phase not select without voltage");
  a_done_pulse: assert property (PKT_DONE_O |=> !PKT_DONE_O)
    else $error("packet done longer than one cycle");
  a_phase_legal: assert property ($changed(PHASE_O) |-> PHASE_O == 3'h0
    || PHASE_O == $past(PHASE_O) + 3'h1 || (PHASE_O == 3'h5 && $past(PHASE_O) == 3'h6)
    || (PHASE_O == 3'h7 && $past(PHASE_O) == 3'h5))
    else $error("illegal phase step");
  a_contract_reneg: assert property ($changed(CONTRACT_O) |-> $past(PHASE_O) == 3'h6
    && CONTRACT_O == $past(CONTRACT_I)) else $error("contract changed outside renegotiation");
  a_half_min: assert property ($fell(MOD_CAP_PIN_A_O) && PHASE_O != 3'h0
    && $past(PHASE_O) != 3'h0 |-> run_reg >= 16'd2490) else $error("switch level too short");
  a_end_stays: assert property ((PHASE_O == 3'h7 && UVLO_OK_I) [*3] |=> PHASE_O == 3'h7)
    else $error("end phase left with voltage present");
  a_cell_max: assert property (run_reg > 16'd5100 |-> !MOD_CAP_PIN_A_O)
    else $error("switch held closed past one cell");
endmodule
bind wprcf_framer wprcf_framer_asserts wprcf_framer_asserts_i (.CLK_I, .RST_I, .UVLO_OK_I,
  .DEMODULATED_INPUT_I, .CONTRACT_I, .PHASE_O, .CONTRACT_O, .MOD_CAP_PIN_A_O,
  .MOD_CAP_PIN_B_O, .PKT_DONE_O);

// [verif/wprcf_framer_tb_top.sv]
// Self-checking bench: walks the framer through every protocol phase.
// Assumes the transmitter model decodes the switch pin; runs a few million cycles.
`timescale 1ns/1ps
`include "wprcf_defines.svh"
module wprcf_framer_tb_top;
  logic clk = 1'b0, rst = 1'b1, uvlo = 1'b0, demodulated_input = 1'b0, end_power_packet = 1'b0, inval = 1'b0;
  logic negd = 1'b0, rreq = 1'b0, rabt = 1'b0, rdone = 1'b0, dsel = 1'b0;
  logic [7:0] ctrl = 8'h00, rxp = 8'h00, sig = 8'h00, nreq = 8'h00, cin = 8'h00;
  logic grant, deny, mod_a, mod_b, pdone, fval;
  logic [2:0] phase;
  logic [7:0] cout, prev_hdr = 8'h00;
  logic [9:0] frm;
  logic [16:0] e;
  logic [16:0] notes [$];
  logic [7:0] b [3];
  int n_errors = 0, cmp_count = 0, nb = 0, seed = 50083;
  always #50 clk = ~clk;
  wprcf_framer wprcf_framer_i (.CLK_I(clk), .RST_I(rst), .UVLO_OK_I(uvlo),
    .DEMODULATED_INPUT_I(demodulated_input), .END_POWER_REQ_I(end_power_packet), .PING_INVALID_I(inval),
    .NEG_DONE_I(negd), .RENEG_REQ_I(rreq), .RENEG_ABORT_I(rabt), .RENEG_DONE_I(rdone),
    .GRANT_I(grant), .DENY_I(deny), .CTRL_ERR_I(ctrl), .RX_POWER_I(rxp),
    .SIG_STRENGTH_I(sig), .NEG_REQ_I(nreq), .CONTRACT_I(cin), .PHASE_O(phase),
    .CONTRACT_O(cout), .MOD_CAP_PIN_A_O(mod_a), .MOD_CAP_PIN_B_O(mod_b), .PKT_DONE_O(pdone));
  wprcf_tx_model wprcf_tx_model_i (.clk_i(clk), .rst_i(rst), .line_i(mod_a),
    .deny_sel_i(dsel), .grant_o(grant), .deny_o(deny), .frame_valid_o(fval), .frame_o(frm));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("%0d comparisons, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A packet lasts about 220000 cycles, hence the generous bounds.
  task wait_pkt;
    for (int i = 0; i < 300000 && pdone !== 1'b1; i++) @(negedge clk);
    check(16'(pdone), 16'h0001);
    repeat (4) @(negedge clk);
  endtask
  task wait_phase(input logic [2:0] p);
    for (int i = 0; i < 600000 && phase !== p; i++) @(negedge clk);
    check(16'(phase), 16'(p));
  endtask
  // Each decoded frame is checked here; every third one closes a packet judged against the oldest note, or by phase when no note is queued.
  always @(negedge clk) begin
    if (fval === 1'b1) begin
      check(16'(frm[9:8]), 16'({1'b1, ~^frm[7:0]}));
      check(16'(mod_b), 16'(mod_a));
      b[nb] = frm[7:0];
      nb = nb + 1;
      if (nb == 3) begin
        nb = 0;
        check(16'(b[2]), 16'(b[0] ^ b[1]));
        if (notes.size() > 0) begin
          e = notes.pop_front();
          check(16'(b[0]), 16'(e[15:8]));
          if (e[16]) check(16'(b[1]), 16'(e[7:0]));
        end else if (phase === 3'h5) begin
          check(16'(b[1]), 16'(b[0] == `WPRCF_HDR_CTRL_ERROR ? ctrl : rxp));
          check(16'(b[0] != prev_hdr), 16'h0001);
          prev_hdr = b[0];
        end else if (phase === 3'h7) begin
          check(16'(b[0]), 16'(`WPRCF_HDR_END_POWER));
        end
      end
    end
  end
  initial begin
    repeat (4000000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    {sig, rxp, ctrl, nreq, cin} <= 40'($random(seed));
    dsel <= 1'($random(seed));
    repeat (20) @(negedge clk);
    check(16'(phase), 16'h0000);
    $display("test select done");
    @(posedge clk);
    demodulated_input <= 1'b1;
    inval <= 1'b1;
    notes.push_back({1'b0, `WPRCF_HDR_END_POWER, 8'h00});
    repeat (3000) @(posedge clk);
    inval <= 1'b0;
    wait_pkt;
    check(16'(phase), 16'h0001);
    notes.push_back({1'b1, `WPRCF_HDR_SIG_STRENGTH, sig});
    wait_pkt;
    check(16'(phase), 16'h0002);
    $display("test ping done");
    @(posedge clk);
    uvlo <= 1'b1;
    demodulated_input <= 1'b0;
    notes.push_back({1'b1, `WPRCF_HDR_IDENT, 8'h00});
    notes.push_back({1'b1, `WPRCF_HDR_CONFIG, 8'h00});
    wait_pkt;
    wait_pkt;
    check(16'(phase), 16'h0003);
    notes.push_back({1'b1, `WPRCF_HDR_NEG_REQ, nreq});
    notes.push_back({1'b1, `WPRCF_HDR_NEG_REQ, nreq});
    wait_pkt;
    // The second request only goes out once the model has answered the first.
    wait_pkt;
    @(posedge clk);
    negd <= 1'b1;
    notes.push_back({1'b1, `WPRCF_HDR_RX_POWER, rxp});
    wait_pkt;
    check(16'(phase), 16'h0005);
    $display("test setup done");
    wait_pkt;
    wait_pkt;
    @(posedge clk);
    rreq <= 1'b1;
    wait_phase(3'h6);
    notes.push_back({1'b1, `WPRCF_HDR_NEG_REQ, nreq});
    @(posedge clk);
    rreq <= 1'b0;
    rabt <= 1'b1;
    wait_phase(3'h5);
    check(16'(cout), 16'h0000);
    @(posedge clk);
    rabt <= 1'b0;
    rreq <= 1'b1;
    wait_phase(3'h6);
    notes.push_back({1'b1, `WPRCF_HDR_NEG_REQ, nreq});
    @(posedge clk);
    rreq <= 1'b0;
    rdone <= 1'b1;
    wait_phase(3'h5);
    check(16'(cout), 16'(cin));
    $display("test reneg done");
    @(posedge clk);
    rdone <= 1'b0;
    end_power_packet <= 1'b1;
    notes.push_back({1'b1, `WPRCF_HDR_END_POWER, 8'h00});
    wait_phase(3'h7);
    wait_pkt;
    wait_pkt;
    check(16'(phase), 16'h0007);
    @(posedge clk);
    uvlo <= 1'b0;
    repeat (10) @(negedge clk);
    check(16'(phase), 16'h0000);
    $display("test end done");
    wrap_up;
  end
endmodule
